// ---- core/ft_can_pkg.sv ----
// Constants and types for the fault-tolerant CAN transceiver control block
package ft_can_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TX_STUCK_US     = 750;
   localparam int TX_RECOVER_US   = 32;
   localparam int WAKE_FILTER_US  = 16;
   localparam int FAULT_FILTER_US = 10;
   localparam int TX_STUCK_CYC    = (TX_STUCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TX_RECOVER_CYC  = (TX_RECOVER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_FILTER_CYC = (WAKE_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAULT_FILT_CYC  = (FAULT_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] FAULT_OFS  = 4'h8;

   localparam int CTRL_MODE_LSB  = 0;
   localparam int ST_MODE_LSB    = 0;
   localparam int ST_STUCK_BIT   = 2;
   localparam int ST_RXSEL_LSB   = 3;
   localparam int ST_WAKE_BIT    = 5;

   // ==========================================================
   // Bus failures: bit index is failure code minus one
   // ==========================================================
   localparam int         FAULT_NUM      = 9;
   localparam logic [8:0] HIGH_FAIL_MASK = 9'h084;
   localparam logic [8:0] LOW_FAIL_MASK  = 9'h068;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      MODE_TXRX     = 2'h0,
      MODE_RXONLY   = 2'h1,
      MODE_BATTERY_TERMINATED_MODE = 2'h3
   } can_mode_t;

   typedef enum logic [1:0] {
      CHIP_NORMAL  = 2'h0,
      CHIP_STANDBY = 2'h1,
      CHIP_STOP    = 2'h3,
      CHIP_SLEEP   = 2'h2
   } chip_state_t;

   typedef enum logic [1:0] {
      RX_DIFF    = 2'h0,
      RX_LOW_SE  = 2'h1,
      RX_HIGH_SE = 2'h3
   } rx_sel_t;

   localparam can_mode_t MODE_RST = MODE_BATTERY_TERMINATED_MODE;

endpackage : ft_can_pkg

// ---- core/ft_can_transceiver_control.sv ----
// Control logic of the fault-tolerant CAN transceiver: modes, faults, wake-up, receive select
`timescale 1ns/1ps
module ft_can_transceiver_control
   import ft_can_pkg::*;
#(
   parameter int TX_STUCK_CYCLES = TX_STUCK_CYC,
   parameter bit RX_WAKE_REPORT  = 1'b1
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Register port
   input  wire logic [3:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata,
   // Chip power state from the mode controller
   input  wire logic [1:0]           chip_state,
   // Protocol controller side
   input  wire logic                 tx_in,
   output logic                      rx_out,
   // Analog comparators and failure detectors
   input  wire logic                 diff_cmp,
   input  wire logic                 high_se_cmp,
   input  wire logic                 low_se_cmp,
   input  wire logic                 wake_cmp,
   input  wire logic [FAULT_NUM-1:0] fault_raw,
   // Driver and termination switches
   output logic                      high_drv_en,
   output logic                      low_drv_en,
   output logic                      high_term_en,
   output logic                      low_term_en,
   output logic                      bat_term_en,
   // Wake-up events to the chip mode controller
   output logic                      wake_normal_req,
   output logic                      wake_irq
);

   // One counter serves both limits, so it must be wide enough for the larger
   localparam int STUCK_MAX = (TX_STUCK_CYCLES > TX_RECOVER_CYC) ?
                              TX_STUCK_CYCLES : TX_RECOVER_CYC;
   localparam int STUCK_W = $clog2(STUCK_MAX + 1);
   localparam int FILT_W  = $clog2(FAULT_FILT_CYC + 1);
   localparam int WAKE_W  = $clog2(WAKE_FILTER_CYC + 1);
   localparam logic [STUCK_W-1:0] STUCK_LIM = STUCK_W'(TX_STUCK_CYCLES);
   localparam logic [STUCK_W-1:0] RECOV_LIM = STUCK_W'(TX_RECOVER_CYC);
   localparam logic [FILT_W-1:0]  FILT_LIM  = FILT_W'(FAULT_FILT_CYC);
   localparam logic [WAKE_W-1:0]  WAKE_LIM  = WAKE_W'(WAKE_FILTER_CYC);

   // ==========================================================
   // Input synchronisation
   // ==========================================================
   logic [FAULT_NUM+4:0] async_in;
   logic [FAULT_NUM+4:0] sync_q;
   logic                 tx_s;
   logic                 diff_s;
   logic                 high_se_s;
   logic                 low_se_s;
   logic                 wake_s;
   logic [FAULT_NUM-1:0] fault_s;

   assign async_in = {fault_raw, wake_cmp, low_se_cmp, high_se_cmp, diff_cmp, tx_in};

   sync2 #(
      .WIDTH (FAULT_NUM + 5)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (async_in),
      .q     (sync_q)
   );

   assign tx_s      = sync_q[0];
   assign diff_s    = sync_q[1];
   assign high_se_s = sync_q[2];
   assign low_se_s  = sync_q[3];
   assign wake_s    = sync_q[4];
   assign fault_s   = sync_q[FAULT_NUM+4:5];

   // ==========================================================
   // Mode selection
   // ==========================================================
   can_mode_t   mode_r;
   can_mode_t   mode_eff;
   chip_state_t chip_st;
   logic        low_power;
   logic        fault_active;

   assign chip_st   = chip_state_t'(chip_state);
   assign low_power = (chip_st == CHIP_SLEEP) || (chip_st == CHIP_STOP);

   // Unused mode code is ignored so only the three modes are reachable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= MODE_RST;
      end else if (reg_wr && reg_addr == CTRL_OFS) begin
         case (reg_wdata[CTRL_MODE_LSB +: 2])
            MODE_TXRX:     mode_r <= MODE_TXRX;
            MODE_RXONLY:   mode_r <= MODE_RXONLY;
            MODE_BATTERY_TERMINATED_MODE: mode_r <= MODE_BATTERY_TERMINATED_MODE;
            default:       mode_r <= mode_r;
         endcase
      end
   end

   assign mode_eff     = low_power ? MODE_BATTERY_TERMINATED_MODE : mode_r;
   assign fault_active = (mode_eff != MODE_BATTERY_TERMINATED_MODE);

   // ==========================================================
   // Bus failure filtering
   // ==========================================================
   logic [FAULT_NUM-1:0] fault_r;

   // Each detector must hold a new level for the filter time before it counts
   genvar gi;
   generate
      for (gi = 0; gi < FAULT_NUM; gi++) begin : g_fault
         logic [FILT_W-1:0] cnt_r;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               cnt_r      <= '0;
               fault_r[gi] <= 1'b0;
            end else if (!fault_active) begin
               cnt_r      <= '0;
               fault_r[gi] <= 1'b0;
            end else if (fault_s[gi] == fault_r[gi]) begin
               cnt_r <= '0;
            end else if (cnt_r >= FILT_LIM - FILT_W'(1)) begin
               cnt_r      <= '0;
               fault_r[gi] <= fault_s[gi];
            end else begin
               cnt_r <= cnt_r + FILT_W'(1);
            end
         end
      end
   endgenerate

   logic high_fail;
   logic low_fail;

   // Open wire, high-to-ground and low-to-supply codes are report only
   assign high_fail = |(fault_r & HIGH_FAIL_MASK);
   assign low_fail  = |(fault_r & LOW_FAIL_MASK);

   // ==========================================================
   // Transmit permanent dominant watch
   // ==========================================================
   logic               tx_stuck_r;
   logic [STUCK_W-1:0] stuck_cnt_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stuck_cnt_r <= '0;
         tx_stuck_r  <= 1'b0;
      end else if (!tx_stuck_r) begin
         if (tx_s) begin
            stuck_cnt_r <= '0;
         end else if (stuck_cnt_r >= STUCK_LIM) begin
            stuck_cnt_r <= '0;
            tx_stuck_r  <= 1'b1;
         end else begin
            stuck_cnt_r <= stuck_cnt_r + STUCK_W'(1);
         end
      end else begin
         if (!tx_s) begin
            stuck_cnt_r <= '0;
         end else if (stuck_cnt_r >= RECOV_LIM) begin
            stuck_cnt_r <= '0;
            tx_stuck_r  <= 1'b0;
         end else begin
            stuck_cnt_r <= stuck_cnt_r + STUCK_W'(1);
         end
      end
   end

   // ==========================================================
   // Drivers and terminations
   // ==========================================================
   logic dominant;
   logic drive_ok;

   assign dominant = !tx_s;
   assign drive_ok = (mode_eff == MODE_TXRX) && !tx_stuck_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_drv_en <= 1'b0;
         low_drv_en  <= 1'b0;
      end else begin
         high_drv_en <= dominant && drive_ok && !high_fail;
         low_drv_en  <= dominant && drive_ok && !low_fail;
      end
   end

   // Battery termination replaces the normal pair in the battery-terminated mode, whether selected by register or forced by a low-power chip state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_term_en <= 1'b0;
         low_term_en  <= 1'b0;
         bat_term_en  <= 1'b1;
      end else begin
         high_term_en <= fault_active && !high_fail;
         low_term_en  <= fault_active && !low_fail;
         bat_term_en  <= !fault_active;
      end
   end

   // ==========================================================
   // Wake-up filter and events
   // ==========================================================
   logic              wake_dom_r;
   logic              wake_dom_d_r;
   logic [WAKE_W-1:0] wake_cnt_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_cnt_r <= '0;
         wake_dom_r <= 1'b0;
      end else if (fault_active || !wake_s) begin
         wake_cnt_r <= '0;
         wake_dom_r <= 1'b0;
      end else if (wake_cnt_r >= WAKE_LIM - WAKE_W'(1)) begin
         wake_dom_r <= 1'b1;
      end else begin
         wake_cnt_r <= wake_cnt_r + WAKE_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_dom_d_r <= 1'b0;
      end else begin
         wake_dom_d_r <= wake_dom_r;
      end
   end

   logic wake_evt;

   assign wake_evt = wake_dom_r && !wake_dom_d_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_normal_req <= 1'b0;
         wake_irq        <= 1'b0;
      end else begin
         wake_normal_req <= wake_evt && (chip_st == CHIP_SLEEP);
         wake_irq        <= wake_evt && (chip_st == CHIP_STOP);
      end
   end

   // Sticky record of a low-power wake; write one clears, a new event wins
   logic wake_seen_r;
   logic wake_clr;

   assign wake_clr = reg_wr && (reg_addr == STATUS_OFS) && reg_wdata[ST_WAKE_BIT];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_seen_r <= 1'b0;
      end else if (wake_evt && low_power) begin
         wake_seen_r <= 1'b1;
      end else if (wake_clr) begin
         wake_seen_r <= 1'b0;
      end
   end

   // ==========================================================
   // Receive path
   // ==========================================================
   rx_sel_t rx_sel;
   logic    rx_nxt;

   always_comb begin
      if (high_fail) begin
         rx_sel = RX_LOW_SE;
      end else if (low_fail) begin
         rx_sel = RX_HIGH_SE;
      end else begin
         rx_sel = RX_DIFF;
      end
   end

   always_comb begin
      rx_nxt = 1'b1;
      if (fault_active) begin
         case (rx_sel)
            RX_DIFF:    rx_nxt = diff_s;
            RX_LOW_SE:  rx_nxt = low_se_s;
            RX_HIGH_SE: rx_nxt = high_se_s;
            default:    rx_nxt = diff_s;
         endcase
      end else if (RX_WAKE_REPORT && !low_power) begin
         rx_nxt = !wake_dom_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_out <= 1'b1;
      end else begin
         rx_out <= rx_nxt;
      end
   end

   // ==========================================================
   // Register read
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         case (reg_addr)
            CTRL_OFS: begin
               reg_rdata[CTRL_MODE_LSB +: 2] <= mode_r;
            end
            STATUS_OFS: begin
               reg_rdata[ST_MODE_LSB +: 2]  <= mode_eff;
               reg_rdata[ST_STUCK_BIT]      <= tx_stuck_r;
               reg_rdata[ST_RXSEL_LSB +: 2] <= rx_sel;
               reg_rdata[ST_WAKE_BIT]       <= wake_seen_r;
            end
            FAULT_OFS: begin
               reg_rdata[FAULT_NUM-1:0] <= fault_r;
            end
            default: begin
               reg_rdata <= '0;
            end
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule : ft_can_transceiver_control

// ---- core/sync2.sv ----
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : sync2

// ---- verif/ft_can_bus_model.sv ----
// Bus-side model: line levels as seen by the comparators
`timescale 1ns/1ps
module ft_can_bus_model (
   input  wire logic high_drv_en,
   input  wire logic low_drv_en,
   input  wire logic other_dom,
   input  wire logic hs_bad,
   input  wire logic ls_bad,
   output logic      diff_cmp,
   output logic      high_se_cmp,
   output logic      low_se_cmp,
   output logic      wake_cmp
);
   logic dom;
   // Any driver on, or another node, makes the bus dominant
   assign dom = high_drv_en | low_drv_en | other_dom;
   // A shorted line reads dominant whatever the bus does
   assign high_se_cmp = hs_bad ? 1'b0 : !dom;
   assign low_se_cmp  = ls_bad ? 1'b0 : !dom;
   assign diff_cmp    = (hs_bad | ls_bad) ? 1'b0 : !dom;
   assign wake_cmp    = dom;
endmodule : ft_can_bus_model

// ---- verif/ft_can_transceiver_control_monitor.sv ----
// Concurrent checks on the transceiver control ports
`timescale 1ns/1ps
module ft_can_transceiver_control_monitor
   import ft_can_pkg::*;
#(
   parameter int TX_STUCK_CYCLES = TX_STUCK_CYC
) (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [1:0]  chip_state,
   input wire logic        tx_in,
   input wire logic        high_drv_en,
   input wire logic        low_drv_en,
   input wire logic        high_term_en,
   input wire logic        low_term_en,
   input wire logic        bat_term_en,
   input wire logic        wake_normal_req,
   input wire logic        wake_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Length of the current dominant run on the transmit input
   logic [31:0] low_cnt_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) low_cnt_r <= '0;
      else if (tx_in) low_cnt_r <= '0;
      else if (low_cnt_r != 32'hffff_ffff) low_cnt_r <= low_cnt_r + 32'h0000_0001;
   end
   chk_recessive_off: assert property (tx_in [*4] |=> !high_drv_en && !low_drv_en)
      else $error("driver on during recessive");
   chk_drv_bat: assert property ((high_drv_en || low_drv_en) |-> !bat_term_en)
      else $error("driver on in battery mode");
   chk_lowpwr_term: assert property ((chip_state == CHIP_SLEEP || chip_state == CHIP_STOP) [*4]
      |-> bat_term_en && !high_drv_en && !low_drv_en)
      else $error("low power without battery termination");
   chk_wake_sleep: assert property (wake_normal_req
      |-> $past(chip_state) == CHIP_SLEEP && !wake_irq)
      else $error("wake request outside sleep");
   chk_irq_stop: assert property (wake_irq |-> $past(chip_state) == CHIP_STOP)
      else $error("wake interrupt outside stop");
   chk_pulse_one: assert property ((wake_irq || wake_normal_req)
      |=> !wake_irq && !wake_normal_req)
      else $error("wake pulse too long");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside answer cycle");
   chk_stuck_off: assert property (low_cnt_r > TX_STUCK_CYCLES + 4
      |-> !high_drv_en && !low_drv_en)
      else $error("driver on after stuck dominant");
   chk_term_drv: assert property (!(high_drv_en && !high_term_en)
      && !(low_drv_en && !low_term_en))
      else $error("driver on with termination off");
endmodule : ft_can_transceiver_control_monitor

// ---- verif/ft_can_transceiver_control_test.sv ----
// Self-checking bench for the transceiver control block
`timescale 1ns/1ps
module ft_can_transceiver_control_test;
   import ft_can_pkg::*;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic        clk, rst_n, reg_wr, reg_rd, tx_in, rx_out, smp, rd_q;
   logic [1:0]  chip_state;
   logic        diff_cmp, high_se_cmp, low_se_cmp, wake_cmp;
   logic [8:0]  fault_raw;
   logic        high_drv_en, low_drv_en, high_term_en, low_term_en, bat_term_en;
   logic        wake_normal_req, wake_irq, other_dom, hs_bad, ls_bad;
   logic [5:0]  pins;
   logic [31:0] nreq, nirq, rdq[$], pq[$];
   int          miscompares, checks;
   assign pins = {rx_out, bat_term_en, low_term_en, high_term_en, low_drv_en, high_drv_en};
   ft_can_transceiver_control #(.TX_STUCK_CYCLES(100)) uut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_state(chip_state),
      .tx_in(tx_in), .rx_out(rx_out), .diff_cmp(diff_cmp), .high_se_cmp(high_se_cmp),
      .low_se_cmp(low_se_cmp), .wake_cmp(wake_cmp), .fault_raw(fault_raw),
      .high_drv_en(high_drv_en), .low_drv_en(low_drv_en), .high_term_en(high_term_en),
      .low_term_en(low_term_en), .bat_term_en(bat_term_en),
      .wake_normal_req(wake_normal_req), .wake_irq(wake_irq));
   ft_can_bus_model bus (
      .high_drv_en(high_drv_en), .low_drv_en(low_drv_en), .other_dom(other_dom),
      .hs_bad(hs_bad), .ls_bad(ls_bad), .diff_cmp(diff_cmp), .high_se_cmp(high_se_cmp),
      .low_se_cmp(low_se_cmp), .wake_cmp(wake_cmp));
   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic print_verdict;
      if (miscompares == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
      rdq.push_back(e);
      @(posedge clk) reg_rd <= 1'b0;
   endtask : rd
   task automatic pn(input logic [5:0] e);
      @(posedge clk) smp <= 1'b1;
      pq.push_back({26'h0, e});
      @(posedge clk) smp <= 1'b0;
   endtask : pn
   task automatic go(input logic t, input int n);
      @(posedge clk) tx_in <= t;
      repeat (n) @(posedge clk);
   endtask : go
   task automatic flt(input logic [8:0] f, input logic h, input logic l);
      @(posedge clk) {fault_raw, hs_bad, ls_bad, tx_in} <= {f, h, l, 1'b1};
      repeat (FAULT_FILT_CYC + 20) @(posedge clk);
   endtask : flt
   task automatic dom(input logic d, input logic [1:0] s);
      @(posedge clk) {other_dom, chip_state} <= {d, s};
      repeat (WAKE_FILTER_CYC + 100) @(posedge clk);
   endtask : dom
   // ==========================================================
   // Clock, watchers and watchdog
   // ==========================================================
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      rd_q <= reg_rd;
      if (wake_normal_req === 1'b1) nreq <= nreq + 32'h1;
      if (wake_irq === 1'b1) nirq <= nirq + 32'h1;
   end
   always @(negedge clk) begin
      if (rd_q) cmp(reg_rdata, rdq.pop_front());
      if (smp) cmp({26'h0, pins}, pq.pop_front());
   end
   initial begin
      #400_000;
      miscompares++;
      print_verdict();
   end
   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      logic b;
      {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, smp, rd_q} = '0;
      {chip_state, fault_raw, other_dom, hs_bad, ls_bad, nreq, nirq} = '0;
      tx_in = 1'b1;
      void'($urandom(32'h1e75_0fc2));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      pn(6'h30);
      rd(STATUS_OFS, 32'h3);
      wr(CTRL_OFS, 32'h2);
      wr(4'hC, 32'hffff_ffff);
      rd(STATUS_OFS, 32'h3);
      rd(4'hC, 32'h0);
      wr(CTRL_OFS, 32'h0);
      for (int i = 0; i < 8; i++) begin
         b = 1'($urandom);
         go(b, 6);
         pn(b ? 6'h2C : 6'h0F);
      end
      go(1'b1, 2);
      wr(CTRL_OFS, 32'h1);
      for (int i = 0; i < 4; i++) begin
         b = 1'($urandom);
         @(posedge clk) {other_dom, tx_in} <= {b, 1'b0};
         repeat (6) @(posedge clk);
         pn({~b, 5'b01100});
      end
      rd(STATUS_OFS, 32'h1);
      @(posedge clk) other_dom <= 1'b0;
      wr(CTRL_OFS, 32'h0);
      flt(9'h004, 1'b1, 1'b0);
      pn(6'h28);
      go(1'b0, 6);
      pn(6'h0A);
      rd(FAULT_OFS, 32'h4);
      rd(STATUS_OFS, 32'h8);
      flt(9'h000, 1'b0, 1'b0);
      go(1'b0, 6);
      pn(6'h0F);
      flt(9'h040, 1'b0, 1'b1);
      go(1'b0, 6);
      pn(6'h05);
      rd(STATUS_OFS, 32'h18);
      rd(FAULT_OFS, 32'h40);
      flt(9'h101, 1'b0, 1'b0);
      go(1'b0, 6);
      pn(6'h0F);
      rd(FAULT_OFS, 32'h101);
      flt(9'h000, 1'b0, 1'b0);
      go(1'b0, 130);
      pn(6'h2C);
      rd(STATUS_OFS, 32'h4);
      go(1'b1, 100);
      rd(STATUS_OFS, 32'h4);
      go(1'b1, 3200);
      go(1'b0, 6);
      pn(6'h0F);
      go(1'b1, 4);
      dom(1'b0, CHIP_SLEEP);
      rd(STATUS_OFS, 32'h3);
      dom(1'b1, CHIP_SLEEP);
      cmp(nreq, 32'h1);
      rd(STATUS_OFS, 32'h23);
      dom(1'b0, CHIP_SLEEP);
      dom(1'b0, CHIP_STOP);
      wr(STATUS_OFS, 32'h20);
      rd(STATUS_OFS, 32'h3);
      dom(1'b1, CHIP_STOP);
      cmp(nirq, 32'h1);
      cmp(nreq, 32'h1);
      dom(1'b0, CHIP_STOP);
      dom(1'b0, CHIP_NORMAL);
      wr(CTRL_OFS, 32'h3);
      dom(1'b1, CHIP_NORMAL);
      pn(6'h10);
      dom(1'b0, CHIP_NORMAL);
      pn(6'h30);
      repeat (4) @(posedge clk);
      print_verdict();
   end
endmodule : ft_can_transceiver_control_test
bind ft_can_transceiver_control ft_can_transceiver_control_monitor
   #(.TX_STUCK_CYCLES(TX_STUCK_CYCLES)) mon (
   .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .chip_state(chip_state), .tx_in(tx_in), .high_drv_en(high_drv_en),
   .low_drv_en(low_drv_en), .high_term_en(high_term_en), .low_term_en(low_term_en),
   .bat_term_en(bat_term_en), .wake_normal_req(wake_normal_req), .wake_irq(wake_irq));
